/* File: design/overlay_pkg.sv */
// Constants and types for the video overlay, window and color key block
package overlay_pkg;

  // Indexed I/O ports: index written at one address, data at the next
  localparam logic [15:0] INDEX_PORT_ADDR = 16'h03D2;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h03D3;

  // Register indices
  localparam logic [7:0] IDX_SECOND_BUFFER_POINTER_HIGH = 8'h27;
  localparam logic [7:0] IDX_LINE_SPAN = 8'h28;
  localparam logic [7:0] IDX_LEFT_LO = 8'h2A;
  localparam logic [7:0] IDX_LEFT_HI = 8'h2B;
  localparam logic [7:0] IDX_RIGHT_LO = 8'h2C;
  localparam logic [7:0] IDX_RIGHT_HI = 8'h2D;
  localparam logic [7:0] IDX_TOP_LO = 8'h2E;
  localparam logic [7:0] IDX_TOP_HI = 8'h2F;
  localparam logic [7:0] IDX_BOTTOM_LO = 8'h30;
  localparam logic [7:0] IDX_BOTTOM_HI = 8'h31;
  localparam logic [7:0] IDX_HORIZONTAL_ZOOM_FACTOR = 8'h32;
  localparam logic [7:0] IDX_VERTICAL_ZOOM_FACTOR = 8'h33;
  localparam logic [7:0] IDX_KEY_CTRL = 8'h3C;
  localparam logic [7:0] IDX_KEY_RED = 8'h3D;
  localparam logic [7:0] IDX_KEY_GREEN = 8'h3E;
  localparam logic [7:0] IDX_KEY_BLUE = 8'h3F;
  localparam logic [7:0] IDX_MASK_RED = 8'h40;
  localparam logic [7:0] IDX_MASK_GREEN = 8'h41;
  localparam logic [7:0] IDX_MASK_BLUE = 8'h42;
  localparam logic [7:0] IDX_LINE_LO = 8'h43;
  localparam logic [7:0] IDX_LINE_HI = 8'h44;

  // Key overlay control bit positions
  localparam int CTL_LSB_DISABLE = 7;
  localparam int CTL_KEY16 = 6;
  localparam int CTL_BLANK_GFX = 5;
  localparam int CTL_XY_EN = 2;
  localparam int CTL_KEY_EN = 1;
  localparam int CTL_OVERLAY_EN = 0;

  // Field widths and positions
  localparam int EDGE_W = 11;
  localparam int EDGE_HI_W = 3;
  localparam int ZOOM_W = 6;
  localparam int ZOOM_LSB = 2;
  localparam int LINE_W = 12;
  localparam int LINE_HI_W = 4;
  localparam int PTR_W = 24;
  localparam int PTR_ALIGN_BITS = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_EDGE_HI = 3'h0;
  localparam logic [5:0] RST_ZOOM = 6'h00;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_t;

  // Graphics pixel layout for key comparison, Gray coded
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_RGB555 = 2'h1,
    MODE_RGB565 = 2'h3
  } key_mode_t;

endpackage

/* File: design/video_overlay_window_color_key.sv */
// Video overlay register file, playback window, zoom and color key mixer
`timescale 1ns/1ps

// Summary of operation
// - Hold second buffer pointer upper byte
// - Hold 8-bit playback line span
// - Left edge: low byte plus three bits
// - Right edge: low byte plus three bits
// - Top line: low byte plus three bits
// - Bottom line: low byte plus three bits
// - Control bit 7 zeroes output colour LSBs
// - Control bit 6 routes green key bit
// - Control bit 5 blanks graphics to zero
// - Bits 4 and 3 writable, reset zero
// - Bit 2 XY region, bit 1 keying
// - Bit 0 enables playback window
// - Three readable writable key value registers
// - Mask bit one excludes key bit
// - Pack 555 and 565 pixels for key
// - Line counter readable as twelve bits
// - Zoom factor applies only when enabled
// - Buffer pointers forced to quad alignment
module video_overlay_window_color_key
  import overlay_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [10:0] pos_x,
  input wire logic [10:0] pos_y,
  input wire logic [LINE_W-1:0] line_count,
  input wire key_mode_t key_mode,
  input wire logic horizontal_zoom_factor_en,
  input wire logic vertical_zoom_factor_en,
  input wire logic [PTR_W-1:0] first_ptr_raw,
  input wire logic [15:0] second_ptr_low_raw,
  input wire pixel_t gfx_pixel,
  input wire pixel_t vid_pixel,
  output pixel_t out_pixel,
  output logic video_sel,
  output logic [PTR_W-1:0] first_buffer_pointer,
  output logic [PTR_W-1:0] second_buffer_pointer,
  output logic [7:0] playback_span,
  output logic [ZOOM_W-1:0] horizontal_zoom_factor,
  output logic [ZOOM_W-1:0] vertical_zoom_factor
);

  logic [7:0] index_q;
  logic [7:0] second_buffer_pointer_hi_q;
  logic [7:0] span_q;
  logic [7:0] left_lo_q;
  logic [EDGE_HI_W-1:0] left_hi_q;
  logic [7:0] right_lo_q;
  logic [EDGE_HI_W-1:0] right_hi_q;
  logic [7:0] top_lo_q;
  logic [EDGE_HI_W-1:0] top_hi_q;
  logic [7:0] bottom_lo_q;
  logic [EDGE_HI_W-1:0] bottom_hi_q;
  logic [ZOOM_W-1:0] horizontal_zoom_factor_q;
  logic [ZOOM_W-1:0] vertical_zoom_factor_q;
  logic [7:0] ctl_q;
  pixel_t key_q;
  pixel_t mask_q;
  logic [LINE_HI_W-1:0] line_hi_hold_q;
  logic line_frozen_q;
  logic [7:0] rdata_q;
  pixel_t out_pixel_q;
  logic video_sel_q;
  logic [PTR_W-1:0] first_buffer_pointer_q;
  logic [PTR_W-1:0] second_buffer_pointer_q;
  logic [7:0] span_out_q;
  logic [ZOOM_W-1:0] horizontal_zoom_factor_out_q;
  logic [ZOOM_W-1:0] vertical_zoom_factor_out_q;

  // Host port decode
  wire index_hit = (io_addr == INDEX_PORT_ADDR);
  wire data_hit = (io_addr == DATA_PORT_ADDR);
  wire wr_index = io_wr && index_hit;
  wire wr_data = io_wr && data_hit;
  wire rd_data = io_rd && data_hit;
  wire rd_index = io_rd && index_hit;

  wire [EDGE_W-1:0] left_edge = {left_hi_q, left_lo_q};
  wire [EDGE_W-1:0] right_edge = {right_hi_q, right_lo_q};
  wire [EDGE_W-1:0] top_line = {top_hi_q, top_lo_q};
  wire [EDGE_W-1:0] bottom_line = {bottom_hi_q, bottom_lo_q};

  // High nibble comes from a copy reloaded every clock unless a low-byte read froze it, so a
  // low-then-high read pair cannot tear across a line boundary
  wire [7:0] line_hi_byte = {4'h0, line_hi_hold_q};

  wire [7:0] rd_mux =
    (index_q == IDX_SECOND_BUFFER_POINTER_HIGH) ? second_buffer_pointer_hi_q :
    (index_q == IDX_LINE_SPAN) ? span_q :
    (index_q == IDX_LEFT_LO) ? left_lo_q :
    (index_q == IDX_LEFT_HI) ? {5'h00, left_hi_q} :
    (index_q == IDX_RIGHT_LO) ? right_lo_q :
    (index_q == IDX_RIGHT_HI) ? {5'h00, right_hi_q} :
    (index_q == IDX_TOP_LO) ? top_lo_q :
    (index_q == IDX_TOP_HI) ? {5'h00, top_hi_q} :
    (index_q == IDX_BOTTOM_LO) ? bottom_lo_q :
    (index_q == IDX_BOTTOM_HI) ? {5'h00, bottom_hi_q} :
    (index_q == IDX_HORIZONTAL_ZOOM_FACTOR) ? {horizontal_zoom_factor_q, 2'h0} :
    (index_q == IDX_VERTICAL_ZOOM_FACTOR) ? {vertical_zoom_factor_q, 2'h0} :
    (index_q == IDX_KEY_CTRL) ? ctl_q :
    (index_q == IDX_KEY_RED) ? key_q.r :
    (index_q == IDX_KEY_GREEN) ? key_q.g :
    (index_q == IDX_KEY_BLUE) ? key_q.b :
    (index_q == IDX_MASK_RED) ? mask_q.r :
    (index_q == IDX_MASK_GREEN) ? mask_q.g :
    (index_q == IDX_MASK_BLUE) ? mask_q.b :
    (index_q == IDX_LINE_LO) ? line_count[7:0] :
    (index_q == IDX_LINE_HI) ? line_hi_byte :
    RST_BYTE;

  wire [7:0] rdata_d = rd_index ? index_q : (rd_data ? rd_mux : rdata_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_q <= RST_BYTE;
      rdata_q <= RST_BYTE;
    end else begin
      if (wr_index) begin
        index_q <= io_wdata;
      end
      rdata_q <= rdata_d;
    end
  end

  wire rd_line_lo = rd_data && (index_q == IDX_LINE_LO);
  wire rd_line_hi = rd_data && (index_q == IDX_LINE_HI);
  // Freeze starts on a low-byte read and ends on the high-byte read
  wire line_frozen_d = rd_line_lo || (line_frozen_q && !rd_line_hi);
  wire line_hi_load = rd_line_lo || !line_frozen_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_hi_hold_q <= 4'h0;
      line_frozen_q <= 1'b0;
    end else begin
      line_frozen_q <= line_frozen_d;
      if (line_hi_load) begin
        line_hi_hold_q <= line_count[LINE_W-1:8];
      end
    end
  end

  // Span, pointer and key registers have no defined reset value;
  // they are cleared anyway so nothing downstream starts unknown
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      second_buffer_pointer_hi_q <= RST_BYTE;
      span_q <= RST_BYTE;
      key_q <= '0;
      mask_q <= '0;
    end else if (wr_data) begin
      if (index_q == IDX_SECOND_BUFFER_POINTER_HIGH) second_buffer_pointer_hi_q <= io_wdata;
      if (index_q == IDX_LINE_SPAN) span_q <= io_wdata;
      if (index_q == IDX_KEY_RED) key_q.r <= io_wdata;
      if (index_q == IDX_KEY_GREEN) key_q.g <= io_wdata;
      if (index_q == IDX_KEY_BLUE) key_q.b <= io_wdata;
      if (index_q == IDX_MASK_RED) mask_q.r <= io_wdata;
      if (index_q == IDX_MASK_GREEN) mask_q.g <= io_wdata;
      if (index_q == IDX_MASK_BLUE) mask_q.b <= io_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_lo_q <= RST_BYTE;
      left_hi_q <= RST_EDGE_HI;
      right_lo_q <= RST_BYTE;
      right_hi_q <= RST_EDGE_HI;
      top_lo_q <= RST_BYTE;
      top_hi_q <= RST_EDGE_HI;
      bottom_lo_q <= RST_BYTE;
      bottom_hi_q <= RST_EDGE_HI;
      horizontal_zoom_factor_q <= RST_ZOOM;
      vertical_zoom_factor_q <= RST_ZOOM;
      ctl_q <= RST_BYTE;
    end else if (wr_data) begin
      if (index_q == IDX_LEFT_LO) left_lo_q <= io_wdata;
      if (index_q == IDX_LEFT_HI) left_hi_q <= io_wdata[2:0];
      if (index_q == IDX_RIGHT_LO) right_lo_q <= io_wdata;
      if (index_q == IDX_RIGHT_HI) right_hi_q <= io_wdata[2:0];
      if (index_q == IDX_TOP_LO) top_lo_q <= io_wdata;
      if (index_q == IDX_TOP_HI) top_hi_q <= io_wdata[2:0];
      if (index_q == IDX_BOTTOM_LO) bottom_lo_q <= io_wdata;
      if (index_q == IDX_BOTTOM_HI) bottom_hi_q <= io_wdata[2:0];
      if (index_q == IDX_HORIZONTAL_ZOOM_FACTOR) horizontal_zoom_factor_q <= io_wdata[7:ZOOM_LSB];
      if (index_q == IDX_VERTICAL_ZOOM_FACTOR) vertical_zoom_factor_q <= io_wdata[7:ZOOM_LSB];
      // Reserved bits 4 and 3 are stored like any other bit
      if (index_q == IDX_KEY_CTRL) ctl_q <= io_wdata;
    end
  end

  // Key comparison: graphics pixel rearranged into key register layout
  logic [23:0] cmp_pix;
  always_comb begin
    cmp_pix = {gfx_pixel.r, gfx_pixel.g, gfx_pixel.b};
    case (key_mode)
      MODE_RGB555: begin
        cmp_pix = {8'h00, 1'b0, gfx_pixel.r[7:3], gfx_pixel.g[7:3],
                   gfx_pixel.b[7:3]};
      end
      MODE_RGB565: begin
        cmp_pix = {8'h00, gfx_pixel.r[7:3], gfx_pixel.g[7:2],
                   gfx_pixel.b[7:3]};
      end
      default: begin
        cmp_pix = {gfx_pixel.r, gfx_pixel.g, gfx_pixel.b};
      end
    endcase
  end

  wire [23:0] key_raw = {key_q.r, key_q.g, key_q.b};
  // One key bit lives in green bit 7; it is compared at blue bit 0
  wire [23:0] key_eff = ctl_q[CTL_KEY16] ?
    {key_raw[23:1], key_q.g[7]} : key_raw;
  wire [23:0] mask_eff = {mask_q.r, mask_q.g, mask_q.b};
  wire key_match =
    (((cmp_pix ^ key_eff) & ~mask_eff) == 24'h000000);

  wire in_window = (pos_x >= left_edge) && (pos_x <= right_edge) &&
                   (pos_y >= top_line) && (pos_y <= bottom_line);
  wire region_ok = ctl_q[CTL_XY_EN] ? in_window : 1'b1;
  wire key_ok = ctl_q[CTL_KEY_EN] ? key_match : 1'b1;
  wire sel_d = ctl_q[CTL_OVERLAY_EN] && region_ok && key_ok;

  wire pixel_t gfx_eff = ctl_q[CTL_BLANK_GFX] ? '0 : gfx_pixel;
  pixel_t mux_pix;
  always_comb begin
    mux_pix = sel_d ? vid_pixel : gfx_eff;
    if (ctl_q[CTL_LSB_DISABLE]) begin
      mux_pix.r[0] = 1'b0;
      mux_pix.g[0] = 1'b0;
      mux_pix.b[0] = 1'b0;
    end
  end

  wire [PTR_W-1:0] first_buffer_pointer_d =
    {first_ptr_raw[PTR_W-1:PTR_ALIGN_BITS], 3'h0};
  wire [PTR_W-1:0] second_buffer_pointer_d =
    {second_buffer_pointer_hi_q, second_ptr_low_raw[15:PTR_ALIGN_BITS], 3'h0};
  wire [ZOOM_W-1:0] horizontal_zoom_factor_d = horizontal_zoom_factor_en ? horizontal_zoom_factor_q : RST_ZOOM;
  wire [ZOOM_W-1:0] vertical_zoom_factor_d = vertical_zoom_factor_en ? vertical_zoom_factor_q : RST_ZOOM;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_pixel_q <= '0;
      video_sel_q <= 1'b0;
    end else begin
      out_pixel_q <= mux_pix;
      video_sel_q <= sel_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_buffer_pointer_q <= '0;
      second_buffer_pointer_q <= '0;
      span_out_q <= RST_BYTE;
      horizontal_zoom_factor_out_q <= RST_ZOOM;
      vertical_zoom_factor_out_q <= RST_ZOOM;
    end else begin
      first_buffer_pointer_q <= first_buffer_pointer_d;
      second_buffer_pointer_q <= second_buffer_pointer_d;
      span_out_q <= span_q;
      horizontal_zoom_factor_out_q <= horizontal_zoom_factor_d;
      vertical_zoom_factor_out_q <= vertical_zoom_factor_d;
    end
  end

  assign io_rdata = rdata_q;
  assign out_pixel = out_pixel_q;
  assign video_sel = video_sel_q;
  assign first_buffer_pointer = first_buffer_pointer_q;
  assign second_buffer_pointer = second_buffer_pointer_q;
  assign playback_span = span_out_q;
  assign horizontal_zoom_factor = horizontal_zoom_factor_out_q;
  assign vertical_zoom_factor = vertical_zoom_factor_out_q;

  AST_SECOND_BUFFER_POINTER_WRITE: assert property (@(posedge clk)
    disable iff (!nrst)
    (wr_data && index_q == IDX_SECOND_BUFFER_POINTER_HIGH) |->
      ##2 (second_buffer_pointer[23:16] == $past(io_wdata, 2)))
    else $error("second pointer high byte not taken");

  AST_PTR_ALIGN: assert property (@(posedge clk)
    disable iff (!nrst)
    (first_buffer_pointer[2:0] == 3'h0) &&
    (second_buffer_pointer[2:0] == 3'h0))
    else $error("buffer pointer not quad aligned");

  AST_EDGE_HI_READ: assert property (@(posedge clk)
    disable iff (!nrst)
    (rd_data && index_q == IDX_LEFT_HI) |=>
      (io_rdata == {5'h00, $past(left_hi_q)}))
    else $error("left edge high readback wrong");

  AST_LSB_DISABLE: assert property (@(posedge clk)
    disable iff (!nrst)
    ctl_q[CTL_LSB_DISABLE] |=>
      (out_pixel.r[0] == 1'b0 && out_pixel.g[0] == 1'b0 &&
       out_pixel.b[0] == 1'b0))
    else $error("colour LSB not forced to zero");

  AST_BLANK_GFX: assert property (@(posedge clk)
    disable iff (!nrst)
    (ctl_q[CTL_BLANK_GFX] && !sel_d) |=> (out_pixel == '0))
    else $error("graphics not blanked");

  AST_GFX_ONLY: assert property (@(posedge clk)
    disable iff (!nrst)
    !ctl_q[CTL_OVERLAY_EN] |=> !video_sel)
    else $error("video shown with overlay off");

  AST_ZOOM_GATE: assert property (@(posedge clk)
    disable iff (!nrst)
    !horizontal_zoom_factor_en |=> (horizontal_zoom_factor == 6'h00))
    else $error("horizontal zoom applied while disabled");

  AST_VZOOM_GATE: assert property (@(posedge clk)
    disable iff (!nrst)
    !vertical_zoom_factor_en |=> (vertical_zoom_factor == 6'h00))
    else $error("vertical zoom applied while disabled");

  AST_ZOOM_PASS: assert property (@(posedge clk)
    disable iff (!nrst)
    horizontal_zoom_factor_en |=> (horizontal_zoom_factor == $past(horizontal_zoom_factor_q)))
    else $error("horizontal zoom factor not passed");

  AST_LINE_HI: assert property (@(posedge clk)
    disable iff (!nrst)
    (rd_data && index_q == IDX_LINE_HI) |=> (io_rdata[7:4] == 4'h0))
    else $error("line counter reserved nibble not zero");

  AST_LINE_LO_READ: assert property (@(posedge clk)
    disable iff (!nrst)
    rd_line_lo |=> (io_rdata == $past(line_count[7:0])))
    else $error("line counter low byte readback wrong");

  AST_LINE_FREEZE: assert property (@(posedge clk)
    disable iff (!nrst)
    (line_frozen_q && !rd_line_lo) |=>
      (line_hi_hold_q == $past(line_hi_hold_q)))
    else $error("line counter high nibble not held");

  AST_PLAIN_OVERLAY: assert property (@(posedge clk)
    disable iff (!nrst)
    (ctl_q[2:0] == 3'b001 && !ctl_q[CTL_LSB_DISABLE]) |=>
      video_sel && (out_pixel == $past(vid_pixel)))
    else $error("overlay without key or region not selected");

  AST_MASKED_KEY: assert property (@(posedge clk)
    disable iff (!nrst)
    (ctl_q[2:0] == 3'b011 && mask_eff == 24'hFFFFFF) |=> video_sel)
    else $error("fully masked key did not match");

  AST_KEY_MISS: assert property (@(posedge clk)
    disable iff (!nrst)
    (ctl_q[CTL_KEY_EN] && !key_match) |=> !video_sel)
    else $error("video shown on key mismatch");

  AST_KEY16: assert property (@(posedge clk)
    disable iff (!nrst)
    (ctl_q[CTL_KEY16] && ctl_q[2:0] == 3'b011 &&
     key_mode == MODE_DIRECT && mask_eff == 24'hFFFFFE &&
     gfx_pixel.b[0] == key_q.g[7]) |=> video_sel)
    else $error("green key bit not used at blue bit 0");

  AST_WINDOW_OUT: assert property (@(posedge clk)
    disable iff (!nrst)
    (ctl_q[CTL_XY_EN] && !in_window) |=> !video_sel)
    else $error("video shown outside the window");

  AST_CTL_WRITE: assert property (@(posedge clk)
    disable iff (!nrst)
    (wr_data && index_q == IDX_KEY_CTRL) |=> (ctl_q == $past(io_wdata)))
    else $error("control register write not stored");

  AST_SPAN_OUT: assert property (@(posedge clk)
    disable iff (!nrst)
    (wr_data && index_q == IDX_LINE_SPAN) |->
      ##2 (playback_span == $past(io_wdata, 2)))
    else $error("line span not passed to output");

endmodule

/* File: test/display_pipe_model.sv */
// Behavioural display pipeline feeding coordinates and pixels to the mixer
`timescale 1ns/1ps
module display_pipe_model
  import overlay_pkg::*;
(
  input wire logic clk,
  input wire logic [10:0] x_req,
  input wire logic [10:0] y_req,
  input wire pixel_t gfx_req,
  input wire pixel_t vid_req,
  output logic [10:0] pos_x,
  output logic [10:0] pos_y,
  output logic [LINE_W-1:0] line_count,
  output pixel_t gfx_pixel,
  output pixel_t vid_pixel
);
  initial begin
    pos_x = '0;
    pos_y = '0;
    line_count = '0;
    gfx_pixel = '0;
    vid_pixel = '0;
  end

  // Scan logic moves away from the sampling edge, and the line counter
  // follows the current row as the real raster would
  always @(negedge clk) begin
    pos_x <= x_req;
    pos_y <= y_req;
    line_count <= {1'b0, y_req};
    gfx_pixel <= gfx_req;
    vid_pixel <= vid_req;
  end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the overlay window and color key mixer
`timescale 1ns/1ps
module tb_top
  import overlay_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  key_mode_t key_mode = MODE_DIRECT;
  logic horizontal_zoom_factor_en = 1'b0;
  logic vertical_zoom_factor_en = 1'b0;
  logic [PTR_W-1:0] first_ptr_raw = 24'h000000;
  logic [15:0] second_ptr_low_raw = 16'h0000;
  logic [10:0] pos_x, pos_y, px, py;
  logic [LINE_W-1:0] line_count;
  pixel_t gfx_pixel, vid_pixel, out_pixel, pg, pv;
  logic video_sel;
  logic [PTR_W-1:0] fbp, sbp;
  logic [7:0] span;
  logic [ZOOM_W-1:0] hz, vz;
  logic [7:0] ctl = 8'h00;
  int num_errors = 0;
  int compares = 0;
  localparam pixel_t VID = 24'h89ABCD;
  localparam pixel_t GFX = 24'h135577;

  always #10 clk = ~clk;

  initial begin
    px = '0;
    py = '0;
    pg = '0;
    pv = '0;
  end

  display_pipe_model display_pipe_model_inst (
    .clk(clk), .x_req(px), .y_req(py), .gfx_req(pg), .vid_req(pv),
    .pos_x(pos_x), .pos_y(pos_y), .line_count(line_count),
    .gfx_pixel(gfx_pixel), .vid_pixel(vid_pixel)
  );

  video_overlay_window_color_key video_overlay_window_color_key_inst (
    .clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .pos_x(pos_x), .pos_y(pos_y), .line_count(line_count),
    .key_mode(key_mode), .horizontal_zoom_factor_en(horizontal_zoom_factor_en), .vertical_zoom_factor_en(vertical_zoom_factor_en),
    .first_ptr_raw(first_ptr_raw), .second_ptr_low_raw(second_ptr_low_raw),
    .gfx_pixel(gfx_pixel), .vid_pixel(vid_pixel), .out_pixel(out_pixel),
    .video_sel(video_sel), .first_buffer_pointer(fbp),
    .second_buffer_pointer(sbp), .playback_span(span),
    .horizontal_zoom_factor(hz), .vertical_zoom_factor(vz)
  );

  task automatic end_sim;
    $display("Mismatches: %0d, comparisons: %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    if (idx == IDX_KEY_CTRL) ctl = d;
    @(negedge clk);
    io_addr = INDEX_PORT_ADDR;
    io_wr = 1'b1;
    io_wdata = idx;
    @(negedge clk);
    io_addr = DATA_PORT_ADDR;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clk);
    io_addr = INDEX_PORT_ADDR;
    io_wr = 1'b1;
    io_wdata = idx;
    @(negedge clk);
    io_wr = 1'b0;
    io_addr = DATA_PORT_ADDR;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    check({16'h0000, io_rdata}, {16'h0000, exp});
  endtask

  // Expected pixel follows blanking and LSB forcing from the shadow control
  task automatic pix(input logic [10:0] x, input logic [10:0] y,
                     input pixel_t g, input logic esel);
    pixel_t e;
    e = esel ? VID : (ctl[CTL_BLANK_GFX] ? pixel_t'(24'h000000) : g);
    if (ctl[CTL_LSB_DISABLE]) e = e & 24'hFEFEFE;
    px = x;
    py = y;
    pg = g;
    pv = VID;
    @(negedge clk);
    @(negedge clk);
    check({23'h0, video_sel}, {23'h0, esel});
    check(out_pixel, e);
  endtask

  task automatic test_reset;
    for (int i = 8'h2A; i <= 8'h33; i++) rd_check(8'(i), 8'h00);
    rd_check(IDX_KEY_CTRL, 8'h00);
  endtask

  task automatic test_regs;
    wr(IDX_SECOND_BUFFER_POINTER_HIGH, 8'hA5);
    rd_check(IDX_SECOND_BUFFER_POINTER_HIGH, 8'hA5);
    wr(IDX_LINE_SPAN, 8'h5A);
    rd_check(IDX_LINE_SPAN, 8'h5A);
    wr(8'h29, 8'h77);
    rd_check(8'h29, 8'h00);
    for (int i = 8'h2A; i <= 8'h31; i++) begin
      wr(8'(i), 8'hFF);
      rd_check(8'(i), i[0] ? 8'h07 : 8'hFF);
    end
    wr(IDX_HORIZONTAL_ZOOM_FACTOR, 8'hFF);
    rd_check(IDX_HORIZONTAL_ZOOM_FACTOR, 8'hFC);
    wr(IDX_VERTICAL_ZOOM_FACTOR, 8'hFF);
    rd_check(IDX_VERTICAL_ZOOM_FACTOR, 8'hFC);
    wr(IDX_KEY_CTRL, 8'h18);
    rd_check(IDX_KEY_CTRL, 8'h18);
    for (int i = 8'h3D; i <= 8'h42; i++) begin
      wr(8'(i), 8'(i) ^ 8'hC3);
      rd_check(8'(i), 8'(i) ^ 8'hC3);
    end
  endtask

  task automatic test_outputs;
    first_ptr_raw = 24'h123457;
    second_ptr_low_raw = 16'hBEEF;
    vertical_zoom_factor_en = 1'b1;
    repeat (3) @(negedge clk);
    check(fbp, 24'h123450);
    check(sbp, 24'hA5BEE8);
    check({16'h0, span}, 24'h00005A);
    check({18'h0, hz}, 24'h000000);
    check({18'h0, vz}, 24'h00003F);
    horizontal_zoom_factor_en = 1'b1;
    vertical_zoom_factor_en = 1'b0;
    repeat (2) @(negedge clk);
    check({18'h0, hz}, 24'h00003F);
    check({18'h0, vz}, 24'h000000);
  endtask

  task automatic test_line;
    py = 11'h5BC;
    repeat (2) @(negedge clk);
    wr(IDX_LINE_LO, 8'h00);
    rd_check(IDX_LINE_LO, 8'hBC);
    // Line moves on between the two halves; the frozen nibble must hold
    py = 11'h6BC;
    repeat (2) @(negedge clk);
    rd_check(IDX_LINE_HI, 8'h05);
    rd_check(IDX_LINE_HI, 8'h06);
  endtask

  task automatic test_window;
    wr(IDX_LEFT_LO, 8'h05);
    wr(IDX_LEFT_HI, 8'h01);
    wr(IDX_RIGHT_LO, 8'h0A);
    wr(IDX_RIGHT_HI, 8'h01);
    wr(IDX_TOP_LO, 8'h02);
    wr(IDX_TOP_HI, 8'h00);
    wr(IDX_BOTTOM_LO, 8'h03);
    wr(IDX_BOTTOM_HI, 8'h00);
    wr(IDX_KEY_CTRL, 8'h05);
    pix(11'h104, 11'h002, GFX, 1'b0);
    pix(11'h105, 11'h002, GFX, 1'b1);
    pix(11'h10A, 11'h003, GFX, 1'b1);
    pix(11'h10B, 11'h003, GFX, 1'b0);
    pix(11'h106, 11'h001, GFX, 1'b0);
    pix(11'h106, 11'h004, GFX, 1'b0);
    wr(IDX_KEY_CTRL, 8'h00);
    pix(11'h106, 11'h002, GFX, 1'b0);
    wr(IDX_KEY_CTRL, 8'h01);
    pix(11'h000, 11'h000, GFX, 1'b1);
    wr(IDX_KEY_CTRL, 8'h81);
    pix(11'h000, 11'h000, GFX, 1'b1);
    wr(IDX_KEY_CTRL, 8'h80);
    pix(11'h000, 11'h000, GFX, 1'b0);
    wr(IDX_KEY_CTRL, 8'h20);
    pix(11'h000, 11'h000, GFX, 1'b0);
  endtask

  // Masks are programmed per mode as host software must
  task automatic keys(input logic [7:0] gk, bk, mg, mb);
    wr(IDX_KEY_GREEN, gk);
    wr(IDX_KEY_BLUE, bk);
    wr(IDX_MASK_GREEN, mg);
    wr(IDX_MASK_BLUE, mb);
  endtask

  task automatic test_key;
    key_mode = MODE_DIRECT;
    wr(IDX_KEY_RED, 8'h12);
    wr(IDX_MASK_RED, 8'h00);
    keys(8'h34, 8'h56, 8'h00, 8'h0F);
    wr(IDX_KEY_CTRL, 8'h03);
    pix(11'h000, 11'h000, 24'h12345A, 1'b1);
    pix(11'h000, 11'h000, 24'h12355A, 1'b0);
    wr(IDX_MASK_RED, 8'hFF);
    key_mode = MODE_RGB555;
    keys(8'h7C, 8'h22, 8'h80, 8'h00);
    pix(11'h000, 11'h000, 24'hF80810, 1'b1);
    pix(11'h000, 11'h000, 24'hF80818, 1'b0);
    key_mode = MODE_RGB565;
    keys(8'hF8, 8'h62, 8'h00, 8'h00);
    pix(11'h000, 11'h000, 24'hF80C10, 1'b1);
    pix(11'h000, 11'h000, 24'hF80810, 1'b0);
    key_mode = MODE_DIRECT;
    keys(8'h80, 8'h00, 8'hFF, 8'hFE);
    wr(IDX_KEY_CTRL, 8'h43);
    pix(11'h000, 11'h000, 24'h000001, 1'b1);
    wr(IDX_KEY_CTRL, 8'h03);
    pix(11'h000, 11'h000, 24'h000001, 1'b0);
    keys(8'h00, 8'h00, 8'hFF, 8'hFF);
    pix(11'h000, 11'h000, GFX, 1'b1);
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    test_reset();
    test_regs();
    test_outputs();
    test_line();
    test_window();
    test_key();
    end_sim();
  end
endmodule
